//--- hw/ldp_pkg.sv
/*
  Shared constants, register map and carrier types for the lamp dimming
  pulse-width controller. Assumes a 125 MHz core clock.
*/
package ldp_pkg;
  localparam int CORE_CLK_HZ = 125_000_000;
  localparam int CORE_CLK_PERIOD_NS = 8;
  localparam int NUM_CH = 8;

  // bus address bytes
  localparam logic [7:0] I2C_WR_BYTE = 8'hDE;
  localparam logic [7:0] I2C_RD_BYTE = 8'hDF;
  localparam logic [6:0] I2C_ADDR7 = I2C_WR_BYTE[7:1];

  // register offsets
  localparam logic [7:0] REG_BRT = 8'h00;
  localparam logic [7:0] REG_OFS_FIRST = 8'h01;
  localparam logic [7:0] REG_OFS_LAST = 8'h08;
  localparam logic [7:0] REG_MEN = 8'h2A;
  localparam logic [7:0] REG_CHEN = 8'h2B;
  localparam logic [7:0] REG_TOUT = 8'h2C;
  localparam logic [7:0] REG_STAT = 8'h40;

  // reset values
  localparam logic [7:0] BRT_RST = 8'h3F;
  localparam logic [5:0] OFS_RST = 6'h00;
  localparam logic MEN_RST = 1'h0;
  localparam logic [7:0] CHEN_RST = 8'h00;
  localparam logic [7:0] TOUT_RST = 8'h80;

  // field positions
  localparam int OFS_W = 6;
  localparam int MEN_BIT = 0;
  localparam int STAT_FAULT_BIT = 0;
  localparam int STAT_LAMP_BIT = 1;
  localparam int STAT_EN_BIT = 2;

  // duty mapping on a 1024-step period
  localparam int PWM_PHASE_W = 10;
  localparam int PWM_STEPS = 1024;
  localparam logic [10:0] DUTY_FLOOR = 11'h029;
  localparam logic [10:0] DUTY_FULL = 11'h400;

  // timing
  localparam int FREE_RUN_HZ = 160;
  localparam int PWM_PRESCALE = CORE_CLK_HZ / (FREE_RUN_HZ * PWM_STEPS);
  localparam int FAULT_TICK_NS = 7_812_500;
  localparam int FAULT_TICK_CYCLES = FAULT_TICK_NS / CORE_CLK_PERIOD_NS;
  localparam int SYNC_LOSS_US = 16_666;
  localparam int SYNC_LOSS_CYCLES = SYNC_LOSS_US * 1000 / CORE_CLK_PERIOD_NS;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } ldp_wr_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_ADDR = 4'b0001,
    ST_AACK = 4'b0010,
    ST_REG = 4'b0011,
    ST_RACK = 4'b0100,
    ST_WDAT = 4'b0101,
    ST_WACK = 4'b0110,
    ST_TX = 4'b0111,
    ST_TACK = 4'b1000
  } ldp_i2c_state_t;
endpackage

//--- hw/ldp_i2c_slave.sv
/*
  Two-wire serial slave: address match, register pointer, auto-increment
  writes and reads. Assumes raw pin levels on i_scl and i_sda, core clock
  much faster than the serial clock; no clock stretching.
*/
module ldp_i2c_slave (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [7:0] i_rd_data,
  output logic [7:0] o_rd_addr,
  output ldp_pkg::ldp_wr_t o_wr,
  output logic o_sda_oe_b
);
  import ldp_pkg::*;

  logic [1:0] scl_s_reg;
  logic [1:0] sda_s_reg;
  logic scl_d_reg;
  logic sda_d_reg;
  ldp_i2c_state_t state_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [7:0] tx_reg;
  logic [7:0] ptr_reg;
  logic rw_reg;
  logic mack_reg;
  logic low_reg;
  ldp_wr_t wr_reg;

  // pin synchronisers, then one delay stage for edges
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      scl_s_reg <= 2'h3;
      sda_s_reg <= 2'h3;
      scl_d_reg <= 1'h1;
      sda_d_reg <= 1'h1;
    end else begin
      scl_s_reg <= {scl_s_reg[0], i_scl};
      sda_s_reg <= {sda_s_reg[0], i_sda};
      scl_d_reg <= scl_s_reg[1];
      sda_d_reg <= sda_s_reg[1];
    end
  end

  wire scl = scl_s_reg[1];
  wire sda = sda_s_reg[1];
  wire scl_high = scl & scl_d_reg;
  wire st_start = scl_high & ~sda & sda_d_reg;
  wire st_stop = scl_high & sda & ~sda_d_reg;
  wire scl_rise = scl & ~scl_d_reg;
  wire scl_fall = ~scl & scl_d_reg;
  wire byte_done = (cnt_reg == 4'h8);
  wire rx_state = (state_reg == ST_ADDR) | (state_reg == ST_REG) | (state_reg == ST_WDAT);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
      tx_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'h0;
      mack_reg <= 1'h0;
      low_reg <= 1'h0;
      wr_reg <= '0;
    end else begin
      wr_reg.en <= 1'h0;
      if (st_start) begin
        state_reg <= ST_ADDR;
        cnt_reg <= 4'h0;
        low_reg <= 1'h0;
      end else if (st_stop) begin
        state_reg <= ST_IDLE;
        low_reg <= 1'h0;
      end else if (scl_rise) begin
        if (rx_state) begin
          sh_reg <= {sh_reg[6:0], sda};
          cnt_reg <= cnt_reg + 4'h1;
        end
        if (state_reg == ST_TX) begin
          tx_reg <= {tx_reg[6:0], 1'h0};
          cnt_reg <= cnt_reg + 4'h1;
        end
        if (state_reg == ST_TACK) begin
          mack_reg <= ~sda;
          if (!sda) ptr_reg <= ptr_reg + 8'h01;
        end
      end else if (scl_fall) begin
        case (state_reg)
          ST_ADDR: if (byte_done) begin
            if (sh_reg[7:1] == I2C_ADDR7) begin
              state_reg <= ST_AACK;
              low_reg <= 1'h1;
              rw_reg <= sh_reg[0];
            end else begin
              state_reg <= ST_IDLE;
            end
          end
          ST_AACK: begin
            cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= ST_TX;
              tx_reg <= i_rd_data;
              low_reg <= ~i_rd_data[7];
            end else begin
              state_reg <= ST_REG;
              low_reg <= 1'h0;
            end
          end
          ST_REG: if (byte_done) begin
            ptr_reg <= sh_reg;
            state_reg <= ST_RACK;
            low_reg <= 1'h1;
          end
          ST_RACK: begin
            state_reg <= ST_WDAT;
            cnt_reg <= 4'h0;
            low_reg <= 1'h0;
          end
          ST_WDAT: if (byte_done) begin
            wr_reg <= '{en: 1'h1, addr: ptr_reg, data: sh_reg};
            state_reg <= ST_WACK;
            low_reg <= 1'h1;
          end
          ST_WACK: begin
            ptr_reg <= ptr_reg + 8'h01;
            state_reg <= ST_WDAT;
            cnt_reg <= 4'h0;
            low_reg <= 1'h0;
          end
          ST_TX: if (byte_done) begin
            state_reg <= ST_TACK;
            low_reg <= 1'h0;
          end else begin
            low_reg <= ~tx_reg[7];
          end
          ST_TACK: if (mack_reg) begin
            state_reg <= ST_TX;
            cnt_reg <= 4'h0;
            tx_reg <= i_rd_data;
            low_reg <= ~i_rd_data[7];
          end else begin
            state_reg <= ST_IDLE;
            low_reg <= 1'h0;
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  assign o_rd_addr = ptr_reg;
  assign o_wr = wr_reg;
  assign o_sda_oe_b = ~low_reg;
endmodule // ldp_i2c_slave

//--- hw/ldp_top.sv
/*
  Eight-channel lamp dimming pulse-width controller with serial register
  access, lamp fault timer and external frequency sync.
  Assumes a 125 MHz core clock, an asynchronous active-low power-on reset,
  and a sync clock from outside that may stop at any time.
*/
// Behaviour
// - slave answers address byte DF for reads and DE for writes
// - serial writes set enables and dimming; serial reads return status
// - one master brightness register sets duty of all eight outputs
// - duty runs about 4% at code 00, 50% at 7F, 100% at FF
// - each channel has a signed offset raising or lowering its duty
// - master enable bit ANDed with enable pin; low holds all outputs low
// - per-channel enable bit; cleared bit keeps that output low
// - fault timer counts while lamps-ok is low, clears when high
// - timeout code 01 to FF sets fault delay, default one second
// - expiry latches all outputs low until reset only
// - timeout code zero disables the fault timeout
// - status reports fault, lamps-ok level and combined enable
// - dimming frequency follows sync input, else free-runs near 160 Hz
// - offsets are six-bit two's complement in bits 5..0, reset zero
module ldp_top #(
  parameter int FAULT_TICK = ldp_pkg::FAULT_TICK_CYCLES,
  parameter int SYNC_LOSS = ldp_pkg::SYNC_LOSS_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_sync_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_en_pin,
  input wire logic i_lamps_ok_pin,
  output logic o_sda_out,
  output logic o_sda_oe_b,
  output logic [ldp_pkg::NUM_CH-1:0] o_dpwm
);
  import ldp_pkg::*;

  localparam int TW = $clog2(FAULT_TICK + 1);
  localparam int LW = $clog2(SYNC_LOSS + 1);

  // saturating brightness plus signed offset
  function automatic logic [7:0] sat_code(input logic [7:0] base, input logic [5:0] ofs);
    logic signed [9:0] sum;
    sum = $signed({2'h0, base}) + $signed({{4{ofs[5]}}, ofs});
    if (sum < 10'sh000) return 8'h00;
    else if (sum > 10'sh0FF) return 8'hFF;
    else return sum[7:0];
  endfunction

  // code to high-time threshold out of 1024 steps
  function automatic logic [10:0] duty_thr(input logic [7:0] code);
    logic [10:0] c3;
    c3 = {3'h0, code} * 11'h003;
    if (code == 8'hFF) return DUTY_FULL;
    else return DUTY_FLOOR + c3 + (c3 >> 2);
  endfunction

  // ---- pin synchronisers
  logic [1:0] en_s_reg;
  logic [1:0] lamp_s_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      en_s_reg <= 2'h0;
      lamp_s_reg <= 2'h0;
    end else begin
      en_s_reg <= {en_s_reg[0], i_en_pin};
      lamp_s_reg <= {lamp_s_reg[0], i_lamps_ok_pin};
    end
  end

  wire en_pin = en_s_reg[1];
  wire lamps_ok_input = lamp_s_reg[1];

  // ---- sync clock domain: toggle on every rising sync edge
  logic sync_tgl_reg;

  always_ff @(posedge i_sync_clk or negedge i_rst_b) begin
    if (!i_rst_b) sync_tgl_reg <= 1'h0;
    else sync_tgl_reg <= ~sync_tgl_reg;
  end

  // toggle crossing into core domain
  logic [2:0] sync_x_reg;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) sync_x_reg <= 3'h0;
    else sync_x_reg <= {sync_x_reg[1:0], sync_tgl_reg};
  end

  wire sync_evt = sync_x_reg[2] ^ sync_x_reg[1];

  // ---- register file
  logic [7:0] brt_reg;
  logic [5:0] ofs_reg [NUM_CH];
  logic men_reg;
  logic [7:0] chen_reg;
  logic [7:0] tout_reg;
  logic fault_reg;

  ldp_wr_t wr;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;

  ldp_i2c_slave u_i2c (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .i_rd_data(rd_data),
    .o_rd_addr(rd_addr),
    .o_wr(wr),
    .o_sda_oe_b(o_sda_oe_b)
  );

  assign o_sda_out = 1'h0;

  // write decode
  wire wr_brt = wr.en & (wr.addr == REG_BRT);
  wire wr_ofs = wr.en & (wr.addr >= REG_OFS_FIRST) & (wr.addr <= REG_OFS_LAST);
  wire wr_men = wr.en & (wr.addr == REG_MEN);
  wire wr_chen = wr.en & (wr.addr == REG_CHEN);
  wire wr_tout = wr.en & (wr.addr == REG_TOUT);
  wire [7:0] wr_ofs_off = wr.addr - REG_OFS_FIRST;
  wire [2:0] wr_ofs_idx = wr_ofs_off[2:0];

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      brt_reg <= BRT_RST;
      men_reg <= MEN_RST;
      chen_reg <= CHEN_RST;
      tout_reg <= TOUT_RST;
    end else begin
      if (wr_brt) brt_reg <= wr.data;
      if (wr_men) men_reg <= wr.data[MEN_BIT];
      if (wr_chen) chen_reg <= wr.data;
      if (wr_tout) tout_reg <= wr.data;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int i = 0; i < NUM_CH; i++) ofs_reg[i] <= OFS_RST;
    end else if (wr_ofs) begin
      ofs_reg[wr_ofs_idx] <= wr.data[OFS_W-1:0];
    end
  end

  // read mux
  wire en_comb = men_reg & en_pin;
  wire [7:0] rd_ofs_off = rd_addr - REG_OFS_FIRST;
  wire [2:0] rd_ofs_idx = rd_ofs_off[2:0];
  wire rd_is_ofs = (rd_addr >= REG_OFS_FIRST) & (rd_addr <= REG_OFS_LAST);
  wire [7:0] rd_ofs_val = {2'h0, ofs_reg[rd_ofs_idx]};
  wire [7:0] stat_val = (8'(fault_reg) << STAT_FAULT_BIT)
                      | (8'(lamps_ok_input) << STAT_LAMP_BIT)
                      | (8'(en_comb) << STAT_EN_BIT);

  assign rd_data = (rd_addr == REG_BRT) ? brt_reg :
                   rd_is_ofs ? rd_ofs_val :
                   (rd_addr == REG_MEN) ? (8'(men_reg) << MEN_BIT) :
                   (rd_addr == REG_CHEN) ? chen_reg :
                   (rd_addr == REG_TOUT) ? tout_reg :
                   (rd_addr == REG_STAT) ? stat_val : 8'h00;

  // ---- sync presence
  logic [LW-1:0] loss_cnt_reg;

  wire sync_present = (loss_cnt_reg != LW'(SYNC_LOSS));

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) loss_cnt_reg <= LW'(SYNC_LOSS);
    else if (sync_evt) loss_cnt_reg <= '0;
    else if (sync_present) loss_cnt_reg <= loss_cnt_reg + LW'(1);
  end

  // ---- dimming timebase
  logic [PWM_PHASE_W-1:0] pre_cnt_reg;
  logic [PWM_PHASE_W-1:0] phase_reg;

  wire pre_wrap = (pre_cnt_reg == PWM_PHASE_W'(PWM_PRESCALE - 1));
  wire restart = sync_evt;

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt_reg <= '0;
      phase_reg <= '0;
    end else if (restart) begin
      pre_cnt_reg <= '0;
      phase_reg <= '0;
    end else if (pre_wrap) begin
      pre_cnt_reg <= '0;
      phase_reg <= phase_reg + PWM_PHASE_W'(1);
    end else begin
      pre_cnt_reg <= pre_cnt_reg + PWM_PHASE_W'(1);
    end
  end

  // ---- lamp fault timer
  logic [TW-1:0] tick_cnt_reg;
  logic [7:0] ftime_reg;

  wire tick_wrap = (tick_cnt_reg == TW'(FAULT_TICK - 1));
  wire tout_off = (tout_reg == 8'h00);
  wire expire = ~lamps_ok_input & ~tout_off & (ftime_reg >= tout_reg);

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) tick_cnt_reg <= '0;
    else if (lamps_ok_input | tick_wrap) tick_cnt_reg <= '0;
    else tick_cnt_reg <= tick_cnt_reg + TW'(1);
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) ftime_reg <= 8'h00;
    else if (lamps_ok_input) ftime_reg <= 8'h00;
    else if (tick_wrap & (ftime_reg != 8'hFF)) ftime_reg <= ftime_reg + 8'h01;
  end

  // only reset clears the latch
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) fault_reg <= 1'h0;
    else if (expire) fault_reg <= 1'h1;
  end

  // ---- channel outputs
  wire run = en_comb & ~fault_reg;
  logic [NUM_CH-1:0] dpwm_reg;

  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    wire [7:0] code = sat_code(brt_reg, ofs_reg[g]);
    wire [10:0] thr = duty_thr(code);
    wire high = ({1'h0, phase_reg} < thr);

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) dpwm_reg[g] <= 1'h0;
      else dpwm_reg[g] <= run & chen_reg[g] & high;
    end
  end

  assign o_dpwm = dpwm_reg;
endmodule // ldp_top

//--- dv/ldp_top_asserts.sv
/* port assertions for ldp_top
   bound to every ldp_top instance, core clock domain only */
module ldp_top_asserts #(
  parameter int FAULT_TICK = 20,
  parameter int SYNC_LOSS = 200
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic i_sync_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_en_pin,
  input wire logic i_lamps_ok_pin,
  input wire logic o_sda_out,
  input wire logic o_sda_oe_b,
  input wire logic [ldp_pkg::NUM_CH-1:0] o_dpwm
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldp_pkg::*;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_b);
  sequence s_start;
    i_scl && $fell(i_sda);
  endsequence
  sequence s_stop;
    i_scl && $rose(i_sda);
  endsequence
  chk_sda_low: assert property (o_sda_out == 1'h0)
    else $error("sda data not low");
  chk_reset_quiet: assert property ($rose(i_rst_b) |-> o_dpwm == '0 && o_sda_oe_b)
    else $error("outputs active after reset");
  chk_en_gate: assert property (!i_en_pin [*4] |-> o_dpwm == '0)
    else $error("output high with enable low");
  chk_start_idle: assert property (s_start |=> o_sda_oe_b [*8])
    else $error("drive after start");
  chk_stop_idle: assert property (s_stop |=> o_sda_oe_b [*8])
    else $error("drive after stop");
  chk_drive_scl: assert property ($fell(o_sda_oe_b) |-> !i_scl)
    else $error("drive began with scl high");
  chk_drive_hold: assert property ($fell(o_sda_oe_b) |=> !o_sda_oe_b [*6])
    else $error("drive too short");
  chk_pulse_min: assert property ($rose(o_dpwm[0]) && i_en_pin |=> o_dpwm[0] [*3])
    else $error("pulse too short");
endmodule // ldp_top_asserts

bind ldp_top ldp_top_asserts #(
  .FAULT_TICK(FAULT_TICK),
  .SYNC_LOSS(SYNC_LOSS)
) u_chk (
  .i_core_clk(i_core_clk),
  .i_rst_b(i_rst_b),
  .i_sync_clk(i_sync_clk),
  .i_scl(i_scl),
  .i_sda(i_sda),
  .i_en_pin(i_en_pin),
  .i_lamps_ok_pin(i_lamps_ok_pin),
  .o_sda_out(o_sda_out),
  .o_sda_oe_b(o_sda_oe_b),
  .o_dpwm(o_dpwm)
);

//--- dv/ldp_i2c_host.sv
/* serial bus master model with write and read tasks
   assumes the bench resolves sda with a pull-up */
module ldp_i2c_host #(
  parameter int HALF = 5
) (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  timeunit 1ns;
  timeprecision 1ps;
  import ldp_pkg::*;
  int tick_len;
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
    tick_len = HALF;
  end
  task automatic tick();
    repeat (tick_len) @(negedge i_clk);
  endtask
  task automatic start();
    o_sda = 1'h1;
    tick();
    o_scl = 1'h1;
    tick();
    o_sda = 1'h0;
    tick();
    o_scl = 1'h0;
    tick();
  endtask
  task automatic stop();
    o_sda = 1'h0;
    tick();
    o_scl = 1'h1;
    tick();
    o_sda = 1'h1;
    tick();
  endtask
  task automatic byte9(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      o_sda = tx[i];
      tick();
      o_scl = 1'h1;
      tick();
      rx[i] = i_sda;
      o_scl = 1'h0;
      tick();
    end
  endtask
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [8:0] r0, r1, r2;
    start();
    byte9({I2C_WR_BYTE, 1'h1}, r0);
    byte9({a, 1'h1}, r1);
    byte9({d, 1'h1}, r2);
    stop();
    ok = !r0[0] && !r1[0] && !r2[0];
  endtask
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    logic [8:0] r0, r1;
    start();
    byte9({I2C_WR_BYTE, 1'h1}, r0);
    byte9({a, 1'h1}, r0);
    start();
    byte9({I2C_RD_BYTE, 1'h1}, r0);
    byte9(9'h1FF, r1);
    stop();
    d = r1[8:1];
  endtask
endmodule // ldp_i2c_host

//--- dv/ldp_top_test.sv
/* self-checking bench for ldp_top with a bus master model
   and a register, status and duty reference model */
module ldp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ldp_pkg::*;
  localparam logic [7:0] ADRS [14] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
    8'h07, 8'h08, 8'h2A, 8'h2B, 8'h2C, 8'h40, 8'h10};
  logic clk, rst_b, sync_clk, sync_run, en_pin, lamps_ok, fault_m;
  logic sda_out, sda_oe_b, host_scl, host_sda;
  logic [7:0] dpwm;
  logic [7:0] m_reg [256];
  wire sda;
  int fail_count, n_checks;
  int cnt [8];
  assign sda = host_sda & (sda_oe_b | sda_out);
  ldp_top #(.FAULT_TICK(20), .SYNC_LOSS(200000)) u_dut (
    .i_core_clk(clk), .i_rst_b(rst_b), .i_sync_clk(sync_clk), .i_scl(host_scl),
    .i_sda(sda), .i_en_pin(en_pin), .i_lamps_ok_pin(lamps_ok), .o_sda_out(sda_out),
    .o_sda_oe_b(sda_oe_b), .o_dpwm(dpwm));
  ldp_i2c_host u_host (.i_clk(clk), .i_sda(sda), .o_scl(host_scl), .o_sda(host_sda));
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    sync_clk = 1'h0;
    #3;
    forever #7.5 sync_clk = sync_run & ~sync_clk;
  end
  function automatic logic [7:0] wmask(input logic [7:0] a);
    if (a == REG_BRT || a == REG_CHEN || a == REG_TOUT) return 8'hFF;
    if (a >= REG_OFS_FIRST && a <= REG_OFS_LAST) return 8'h3F;
    return (a == REG_MEN) ? 8'h01 : 8'h00;
  endfunction
  function automatic logic [7:0] rd_model(input logic [7:0] a);
    if (a == REG_STAT) return {5'h00, m_reg[REG_MEN][0] & en_pin, lamps_ok, fault_m};
    return m_reg[a];
  endfunction
  function automatic int thr_of(input logic [7:0] a);
    int c;
    c = int'(m_reg[REG_BRT]) + int'($signed(m_reg[a][5:0]));
    c = (c < 0) ? 0 : (c > 255) ? 255 : c;
    return (c == 255) ? 1024 : 41 + 3 * c + (3 * c) / 4;
  endfunction
  task automatic mreset();
    foreach (m_reg[i]) m_reg[i] = 8'h00;
    m_reg[REG_BRT] = 8'h3F;
    m_reg[REG_TOUT] = 8'h80;
    fault_m = 1'h0;
  endtask
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_cnt(input int got, input int exp);
    n_checks++;
    if (got > exp + exp / 500 + 16 || got < exp - exp / 500 - 16) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    u_host.write_reg(a, d, ok);
    cmp8({7'h00, ok}, 8'h01);
    if (a != REG_STAT) m_reg[a] = d & wmask(a);
  endtask
  task automatic rd(input logic [7:0] a);
    logic [7:0] d;
    u_host.read_reg(a, d);
    cmp8(d, rd_model(a));
  endtask
  task automatic burst(input int n);
    sync_run = 1'h1;
    repeat (n) @(negedge clk);
  endtask
  task automatic complete_run();
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    complete_run();
  end
  initial begin
    logic [8:0] r9;
    rst_b = 1'h0;
    en_pin = 1'h1;
    lamps_ok = 1'h1;
    sync_run = 1'h0;
    mreset();
    void'($urandom(32'h10063323));
    repeat (16) @(negedge clk);
    rst_b = 1'h1;
    repeat (4) @(negedge clk);
    foreach (ADRS[i]) rd(ADRS[i]);
    foreach (ADRS[i]) begin
      wr(ADRS[i], 8'($urandom));
      rd(ADRS[i]);
    end
    u_host.tick_len = 12;
    u_host.start();
    u_host.byte9({8'hDC, 1'h1}, r9);
    u_host.stop();
    u_host.tick_len = 5;
    cmp8({7'h00, r9[0]}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      wr(REG_MEN, {7'h00, k[1]});
      en_pin = k[0];
      wr(REG_CHEN, 8'($urandom));
      rd(REG_STAT);
      burst(40);
      cmp8(dpwm, (k == 3) ? m_reg[REG_CHEN] : 8'h00);
      sync_run = 1'h0;
    end
    wr(REG_CHEN, 8'hFF);
    wr(REG_BRT, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(REG_OFS_FIRST + 8'(i), (i == 1) ? 8'h20 : 8'($urandom_range(0, 3)) |
        ($urandom_range(0, 1) ? 8'h3C : 8'h00));
    end
    burst(20);
    sync_run = 1'h0;
    cnt = '{default: 0};
    for (int n = 0; n < 60000 && dpwm !== 8'h00; n++) begin
      @(negedge clk);
      foreach (cnt[i]) cnt[i] += int'(dpwm[i]);
    end
    foreach (cnt[i]) cmp_cnt(cnt[i], thr_of(REG_OFS_FIRST + 8'(i)) * PWM_PRESCALE);
    wr(REG_TOUT, 8'h03);
    repeat (2) begin
      lamps_ok = 1'h0;
      repeat (40) @(negedge clk);
      lamps_ok = 1'h1;
      repeat (10) @(negedge clk);
    end
    rd(REG_STAT);
    wr(REG_TOUT, 8'h00);
    lamps_ok = 1'h0;
    repeat (300) @(negedge clk);
    rd(REG_STAT);
    wr(REG_TOUT, 8'h02);
    fault_m = 1'h1;
    rd(REG_STAT);
    lamps_ok = 1'h1;
    wr(REG_MEN, 8'h01);
    burst(40);
    cmp8(dpwm, 8'h00);
    sync_run = 1'h0;
    rd(REG_STAT);
    rst_b = 1'h0;
    repeat (4) @(negedge clk);
    rst_b = 1'h1;
    mreset();
    repeat (4) @(negedge clk);
    rd(REG_STAT);
    rd(REG_TOUT);
    complete_run();
  end
endmodule // ldp_top_test
